//--- design/mtc_top.sv
// What this block does
// - descriptor read with interrupt request newly set sets programmable transmit interrupt flag
// - collision timer starts after delimiter when select is 0, first preamble bit when 1
// - fcs suppress 0 appends four byte check sequence, 1 sends without it
// - deferral timer disable 0 enables the deferral timer, 1 disables it
// - after 3.2 ms continuous deferral set flag, abort if timer enabled
//
// The register offsets and register access over APB were chosen for this implementation.
`include "mtc_params.svh"

module mtc_top
  import mtc_pkg::*;
#(
  parameter logic [23:0] DEFER_CYCLES =
    24'((`MTC_DEFER_TIME_NS + `MTC_CLK_PERIOD_NS - 1) / `MTC_CLK_PERIOD_NS)
) (
  input  wire logic        CLOCK_I,
  input  wire logic        NRST_I,
  input  wire logic        CE_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  input  wire logic [3:0]  PSTRB_I,
  output logic             PREADY_O,
  output logic [31:0]      PRDATA_O,
  output logic             PSLVERR_O,
  input  wire logic        DESC_VALID_I,
  input  wire logic [15:0] DESC_CFG_I,
  input  wire logic        TX_PREAMBLE_START_I,
  input  wire logic        TX_SFD_END_I,
  input  wire logic        DEFERRING_I,
  output logic             COLL_TIMER_START_O,
  output logic             FCS_APPEND_O,
  output logic [2:0]       FCS_LEN_O,
  output logic             TX_ABORT_O,
  output logic             IRQ_O
);

  // address decode, used by both the read path and the write path
  function automatic mtc_sel_e mtc_decode(input logic [11:0] addr);
    mtc_sel_e sel;
    sel = MTC_SEL_NONE;
    if (addr == `MTC_OFS_CTRL) begin
      sel = MTC_SEL_CTRL;
    end else if (addr == `MTC_OFS_INT_STATUS) begin
      sel = MTC_SEL_STATUS_INT;
    end else if (addr == `MTC_OFS_INT_MASK) begin
      sel = MTC_SEL_MASK;
    end else if (addr == `MTC_OFS_STATUS) begin
      sel = MTC_SEL_STATUS;
    end
    return sel;
  endfunction

  mtc_ctrl_s   ctrl_reg;
  mtc_ctrl_s   ctrl_next;
  mtc_irq_s    status_reg;
  mtc_irq_s    status_next;
  mtc_irq_s    mask_reg;
  mtc_irq_s    mask_next;
  mtc_irq_s    event_set;
  mtc_irq_s    event_clr;
  logic        pready_reg;
  logic        pready_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pslverr_reg;
  logic        pslverr_next;
  logic        held_req_reg;
  logic        held_req_next;
  logic [23:0] defer_cnt_reg;
  logic [23:0] defer_cnt_next;
  logic        coll_start_reg;
  logic        coll_start_next;
  logic        fcs_append_reg;
  logic        fcs_append_next;
  logic [2:0]  fcs_len_reg;
  logic [2:0]  fcs_len_next;
  logic        abort_reg;
  logic        abort_next;
  logic        irq_reg;
  logic        irq_next;
  logic        bus_write;
  logic        pti_event;
  logic        exd_event;
  mtc_sel_e    setup_sel;
  mtc_sel_e    access_sel;

  // a write lands only on the access edge where ready is already high
  assign bus_write  = PSEL_I & PENABLE_I & pready_reg & PWRITE_I;
  assign setup_sel  = mtc_decode(PADDR_I);
  assign access_sel = setup_sel;

  // a new request is one that rises against the held copy, so a request
  // left high across two descriptors raises nothing the second time
  assign pti_event = DESC_VALID_I & DESC_CFG_I[`MTC_CFG_REQ_BIT] & ~held_req_reg;

  // the deferral limit fires once per episode, the counter then saturates
  assign exd_event = DEFERRING_I & (defer_cnt_reg == DEFER_CYCLES - 24'h1);

  // apb slave: answer is prepared during setup, so an access whose setup is sampled with the clock enable high takes one cycle
  always_comb begin
    pready_next  = 1'b0;
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;
    if (PSEL_I & ~PENABLE_I) begin
      pready_next  = 1'b1;
      prdata_next  = 32'h0000_0000;
      pslverr_next = (setup_sel == MTC_SEL_NONE);
      if (!PWRITE_I) begin
        unique case (setup_sel)
          MTC_SEL_CTRL:       prdata_next = {29'h0, ctrl_reg};
          MTC_SEL_STATUS_INT: prdata_next = {30'h0, status_reg};
          MTC_SEL_MASK:       prdata_next = {30'h0, mask_reg};
          MTC_SEL_STATUS:     prdata_next = {30'h0, DEFERRING_I, held_req_reg};
          MTC_SEL_NONE:       prdata_next = 32'h0000_0000;
        endcase
      end
    end
  end

  // control and mask registers; only the low byte lane carries bits
  always_comb begin
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    if (bus_write && PSTRB_I[0]) begin
      if (access_sel == MTC_SEL_CTRL) begin
        ctrl_next = mtc_ctrl_s'(PWDATA_I[2:0]);
      end
      if (access_sel == MTC_SEL_MASK) begin
        mask_next = mtc_irq_s'(PWDATA_I[1:0]);
      end
    end
  end

  // sticky status, write one to clear; a set in the same cycle wins
  always_comb begin
    event_set = '0;
    event_clr = '0;
    event_set.programmable_tx_interrupt_flag = pti_event;
    event_set.excessive_deferral_flag        = exd_event;
    if (bus_write && PSTRB_I[0] && access_sel == MTC_SEL_STATUS_INT) begin
      event_clr = mtc_irq_s'(PWDATA_I[1:0]);
    end
    status_next = (status_reg & ~event_clr) | event_set;
    irq_next    = |(status_next & mask_next);
  end

  // held copy of the descriptor request, refreshed on every descriptor read while the clock enable is high
  always_comb begin
    held_req_next = held_req_reg;
    if (DESC_VALID_I) begin
      held_req_next = DESC_CFG_I[`MTC_CFG_REQ_BIT];
    end
  end

  // deferral counter clears whenever deferral stops; the flag is always
  // reported, only the abort is gated by the disable bit
  always_comb begin
    defer_cnt_next = 24'h0;
    if (DEFERRING_I) begin
      defer_cnt_next = defer_cnt_reg;
      if (defer_cnt_reg != DEFER_CYCLES) begin
        defer_cnt_next = defer_cnt_reg + 24'h1;
      end
    end
    abort_next = exd_event & ~ctrl_reg.deferral_timer_disable;
  end

  // transmitter steering from the option bits
  always_comb begin
    coll_start_next = ctrl_reg.late_collision_timer_start_select ?
                      TX_PREAMBLE_START_I : TX_SFD_END_I;
    fcs_append_next = ~ctrl_reg.fcs_suppress;
    fcs_len_next    = ctrl_reg.fcs_suppress ? 3'h0 : `MTC_FCS_BYTES;
  end

  // all state freezes while the clock enable is low
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ctrl_reg       <= mtc_ctrl_s'(`MTC_CTRL_RST);
      mask_reg       <= mtc_irq_s'(`MTC_INT_RST);
      status_reg     <= mtc_irq_s'(`MTC_INT_RST);
      pready_reg     <= 1'b0;
      prdata_reg     <= 32'h0000_0000;
      pslverr_reg    <= 1'b0;
      held_req_reg   <= 1'b0;
      defer_cnt_reg  <= 24'h0;
      coll_start_reg <= 1'b0;
      fcs_append_reg <= 1'b1;
      fcs_len_reg    <= `MTC_FCS_BYTES;
      abort_reg      <= 1'b0;
      irq_reg        <= 1'b0;
    end else if (CE_I) begin
      ctrl_reg       <= ctrl_next;
      mask_reg       <= mask_next;
      status_reg     <= status_next;
      pready_reg     <= pready_next;
      prdata_reg     <= prdata_next;
      pslverr_reg    <= pslverr_next;
      held_req_reg   <= held_req_next;
      defer_cnt_reg  <= defer_cnt_next;
      coll_start_reg <= coll_start_next;
      fcs_append_reg <= fcs_append_next;
      fcs_len_reg    <= fcs_len_next;
      abort_reg      <= abort_next;
      irq_reg        <= irq_next;
    end
  end

  assign PREADY_O           = pready_reg;
  assign PRDATA_O           = prdata_reg;
  assign PSLVERR_O          = pslverr_reg;
  assign COLL_TIMER_START_O = coll_start_reg;
  assign FCS_APPEND_O       = fcs_append_reg;
  assign FCS_LEN_O          = fcs_len_reg;
  assign TX_ABORT_O         = abort_reg;
  assign IRQ_O              = irq_reg;

  // checks, all in the system clock domain
  default clocking mtc_cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!NRST_I);

  chk_pti_new_request: assert property (
    CE_I && DESC_VALID_I && DESC_CFG_I[`MTC_CFG_REQ_BIT] && !held_req_reg
    |=> status_reg.programmable_tx_interrupt_flag)
    else $error("request on descriptor did not set the interrupt flag");

  chk_pti_held_quiet: assert property (
    CE_I && !status_reg.programmable_tx_interrupt_flag && held_req_reg && !bus_write
    && !(DESC_VALID_I && !DESC_CFG_I[`MTC_CFG_REQ_BIT])
    ##1 CE_I && DESC_VALID_I && DESC_CFG_I[`MTC_CFG_REQ_BIT]
    |=> !status_reg.programmable_tx_interrupt_flag)
    else $error("held request raised a second interrupt");

  chk_coll_after_sfd: assert property (
    CE_I && !ctrl_reg.late_collision_timer_start_select
    |=> COLL_TIMER_START_O == $past(TX_SFD_END_I))
    else $error("collision timer start not tied to delimiter end");

  chk_coll_preamble: assert property (
    CE_I && ctrl_reg.late_collision_timer_start_select
    |=> COLL_TIMER_START_O == $past(TX_PREAMBLE_START_I))
    else $error("collision timer start not tied to first preamble bit");

  chk_fcs_length: assert property (
    CE_I |=> FCS_LEN_O == ($past(ctrl_reg.fcs_suppress) ? 3'h0 : 3'h4)
    && FCS_APPEND_O == !$past(ctrl_reg.fcs_suppress))
    else $error("check sequence length does not follow suppress bit");

  chk_abort_disabled: assert property (
    CE_I && ctrl_reg.deferral_timer_disable |=> !TX_ABORT_O)
    else $error("abort while deferral timer disabled");

  chk_defer_limit: assert property (
    CE_I && DEFERRING_I && defer_cnt_reg == DEFER_CYCLES - 24'h1
    |=> status_reg.excessive_deferral_flag
    && TX_ABORT_O == !$past(ctrl_reg.deferral_timer_disable))
    else $error("deferral limit did not flag or abort");

  // an abort held across a frozen cycle is not a fresh one, so the edge before must have run
  chk_defer_early: assert property (
    CE_I && $past(CE_I) && TX_ABORT_O |-> $past(defer_cnt_reg) == DEFER_CYCLES - 24'h1)
    else $error("abort before the deferral limit");

  chk_irq_level: assert property (
    CE_I && |(status_reg & mask_reg) ##1 CE_I && |(status_reg & mask_reg) |-> IRQ_O)
    else $error("interrupt output low with unmasked status set");

  // only a descriptor read may raise the programmable flag; a bus write only clears
  chk_pti_needs_desc: assert property (
    CE_I && !status_reg.programmable_tx_interrupt_flag && !DESC_VALID_I
    |=> !status_reg.programmable_tx_interrupt_flag)
    else $error("interrupt flag set without a descriptor read");

  chk_held_follows: assert property (
    CE_I && DESC_VALID_I |=> held_req_reg == $past(DESC_CFG_I[`MTC_CFG_REQ_BIT]))
    else $error("held request copy did not follow the descriptor");

  chk_abort_one_cycle: assert property (
    CE_I && TX_ABORT_O |=> !TX_ABORT_O)
    else $error("abort stood longer than one cycle");

  // a gap in deferral restarts the count, so the limit needs continuous deferral
  chk_defer_restart: assert property (
    CE_I && !DEFERRING_I |=> defer_cnt_reg == 24'h0)
    else $error("deferral count survived a gap in deferral");

  chk_exd_needs_defer: assert property (
    CE_I && !status_reg.excessive_deferral_flag && !DEFERRING_I
    |=> !status_reg.excessive_deferral_flag)
    else $error("deferral flag set while not deferring");

  chk_freeze_state: assert property (
    !CE_I |=> $stable(ctrl_reg) && $stable(status_reg) && $stable(held_req_reg))
    else $error("state moved while the clock enable was low");

  cov_pti_event: cover property (CE_I && pti_event ##1 IRQ_O);
  cov_defer_abort: cover property (CE_I && TX_ABORT_O);
  cov_status_clear: cover property (
    status_reg.programmable_tx_interrupt_flag ##1 !status_reg.programmable_tx_interrupt_flag);
  cov_preamble_start: cover property (
    ctrl_reg.late_collision_timer_start_select && COLL_TIMER_START_O);
  cov_defer_disabled: cover property (
    CE_I && ctrl_reg.deferral_timer_disable && exd_event);

endmodule

//--- design/mtc_params.svh
`ifndef MTC_PARAMS_SVH
`define MTC_PARAMS_SVH

// apb register byte offsets
`define MTC_OFS_CTRL       12'h000
`define MTC_OFS_INT_STATUS 12'h004
`define MTC_OFS_INT_MASK   12'h008
`define MTC_OFS_STATUS     12'h00c

// reset values
`define MTC_CTRL_RST       3'h0
`define MTC_INT_RST        2'h0

// field positions in the descriptor configuration word
`define MTC_CFG_REQ_BIT    15

// frame check sequence length in bytes
`define MTC_FCS_BYTES      3'h4

// timing
`define MTC_CLK_PERIOD_NS  8
`define MTC_DEFER_TIME_NS  3200000

`endif

//--- design/mtc_pkg.sv
package mtc_pkg;

  // transmit control options, low bits of the control register
  typedef struct packed {
    logic deferral_timer_disable;
    logic late_collision_timer_start_select;
    logic fcs_suppress;
  } mtc_ctrl_s;

  // sticky event bits, shared layout of interrupt status and mask
  typedef struct packed {
    logic excessive_deferral_flag;
    logic programmable_tx_interrupt_flag;
  } mtc_irq_s;

  // decoded register selection
  typedef enum {
    MTC_SEL_CTRL,
    MTC_SEL_STATUS_INT,
    MTC_SEL_MASK,
    MTC_SEL_STATUS,
    MTC_SEL_NONE
  } mtc_sel_e;

endpackage

//--- bench/mtc_host_mem.sv
// host memory side: hands out transmit descriptor config words on request
module mtc_host_mem (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        fetch_i,
  input  wire logic        repeat_i,
  output logic             desc_valid_o,
  output logic [15:0]      desc_cfg_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic req_reg;
  // idle word lines invert on every idle cycle so a stale word never passes for a fresh one
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req_reg      <= 1'b0;
      desc_valid_o <= 1'b0;
      desc_cfg_o   <= 16'h0000;
    end else if (fetch_i) begin
      // request bit alternates unless repeat_i resends the last one, so only without repeat_i does at most every second descriptor ask
      req_reg      <= repeat_i ? req_reg : ~req_reg;
      desc_valid_o <= 1'b1;
      desc_cfg_o   <= {(repeat_i ? req_reg : ~req_reg), 15'h1234};
    end else begin
      desc_valid_o <= 1'b0;
      desc_cfg_o   <= ~desc_cfg_o;
    end
  end
endmodule

//--- bench/test_mac_transmit_control_options.sv
`include "mtc_params.svh"
module test_mac_transmit_control_options;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int D = 20;
  logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, ce = 1'b1;
  logic        sfd = 1'b0, pre = 1'b0, dfr = 1'b0, fetch = 1'b0, rep = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, dv, cstart, fapp, abrt, irq;
  logic [15:0] dcfg;
  logic [2:0]  flen;
  int          miscompares = 0, checked = 0, cyc = 0;
  // rows: control value, expected append flag, expected check sequence length
  logic [6:0]  rows [5] = '{7'h0c, 7'h10, 7'h2c, 7'h30, 7'h4c};

  mtc_top #(.DEFER_CYCLES(24'(D))) dut (.CLOCK_I(clk), .NRST_I(nrst), .CE_I(ce),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PSTRB_I(4'hf), .PREADY_O(pready), .PRDATA_O(prdata), .PSLVERR_O(pslverr),
    .DESC_VALID_I(dv), .DESC_CFG_I(dcfg), .TX_PREAMBLE_START_I(pre), .TX_SFD_END_I(sfd),
    .DEFERRING_I(dfr), .COLL_TIMER_START_O(cstart), .FCS_APPEND_O(fapp),
    .FCS_LEN_O(flen), .TX_ABORT_O(abrt), .IRQ_O(irq));
  mtc_host_mem host (.clk_i(clk), .nrst_i(nrst), .fetch_i(fetch), .repeat_i(rep),
    .desc_valid_o(dv), .desc_cfg_o(dcfg));

  // free running clock
  always #4 clk = ~clk;

  task automatic results();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // no wait count is assumed here; only the hang guard ends a stuck access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    check(q, exp);
  endtask

  // one cycle frame event; the start pulse is looked at in the following cycle
  task automatic tx_pulse(input logic p, input logic exp);
    @(posedge clk);
    if (p) pre <= 1'b1;
    else sfd <= 1'b1;
    @(posedge clk);
    pre <= 1'b0;
    sfd <= 1'b0;
    @(negedge clk);
    check(cstart, exp);
  endtask

  task automatic fetch_desc(input logic r);
    @(posedge clk);
    fetch <= 1'b1;
    rep <= r;
    @(posedge clk);
    fetch <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // continuous deferral of n cycles; notes where and how often an abort shows
  task automatic defer(input int n, output int f, output int c);
    f = 0;
    c = 0;
    dfr <= 1'b1;
    for (int i = 1; i <= n; i++) begin
      @(negedge clk);
      if (abrt === 1'b1) begin
        c++;
        if (f == 0) f = i;
      end
    end
    @(posedge clk);
    dfr <= 1'b0;
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    int f, c;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    check(fapp, 1'b1);
    check(flen, 3'h4);
    check(irq, 1'b0);
    rdchk(`MTC_OFS_CTRL, 32'h0);
    rdchk(12'h010, 32'h0);
    check(pslverr, 1'b1);
    // ordinary cases: control values 0 through 4
    foreach (rows[i]) begin
      wr(`MTC_OFS_CTRL, {29'h0, rows[i][6:4]});
      repeat (2) @(negedge clk);
      check(fapp, rows[i][3]);
      check(flen, rows[i][2:0]);
      tx_pulse(1'b0, ~rows[i][5]);
      tx_pulse(1'b1, rows[i][5]);
    end
    wr(`MTC_OFS_CTRL, 32'h0);
    // descriptor interrupt, masked then unmasked, then a repeated request
    fetch_desc(1'b0);
    rdchk(`MTC_OFS_INT_STATUS, 32'h1);
    check(irq, 1'b0);
    wr(`MTC_OFS_INT_MASK, 32'h3);
    repeat (2) @(negedge clk);
    check(irq, 1'b1);
    rdchk(`MTC_OFS_INT_MASK, 32'h3);
    wr(`MTC_OFS_INT_STATUS, 32'h1);
    rdchk(`MTC_OFS_INT_STATUS, 32'h0);
    check(irq, 1'b0);
    fetch_desc(1'b1);
    rdchk(`MTC_OFS_INT_STATUS, 32'h0);
    fetch_desc(1'b0);
    fetch_desc(1'b0);
    rdchk(`MTC_OFS_INT_STATUS, 32'h1);
    wr(`MTC_OFS_INT_STATUS, 32'h1);
    // a descriptor read while the clock enable is low must leave the held copy alone
    ce <= 1'b0;
    fetch_desc(1'b0);
    ce <= 1'b1;
    rdchk(`MTC_OFS_STATUS, 32'h1);
    fetch_desc(1'b0);
    rdchk(`MTC_OFS_INT_STATUS, 32'h0);
    // excessive deferral with the timer enabled, disabled, and cut short
    defer(2 * D, f, c);
    check(32'(f), 32'(D + 1));
    check(32'(c), 32'h1);
    rdchk(`MTC_OFS_INT_STATUS, 32'h2);
    wr(`MTC_OFS_INT_STATUS, 32'h2);
    wr(`MTC_OFS_CTRL, 32'h4);
    defer(2 * D, f, c);
    check(32'(c), 32'h0);
    rdchk(`MTC_OFS_INT_STATUS, 32'h2);
    wr(`MTC_OFS_INT_STATUS, 32'h2);
    wr(`MTC_OFS_CTRL, 32'h0);
    defer(D - 1, f, c);
    check(32'(c), 32'h0);
    rdchk(`MTC_OFS_INT_STATUS, 32'h0);
    // reset in mid-run brings every option back to its reset value
    wr(`MTC_OFS_CTRL, 32'h1);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    check(fapp, 1'b1);
    check(flen, 3'h4);
    rdchk(`MTC_OFS_CTRL, 32'h0);
    rdchk(`MTC_OFS_INT_MASK, 32'h0);
    results();
  end
endmodule
